/* common/pgd_pkg.sv */
// Shared constants and types of the looping pattern generator
// What this block does
// RQ1: Auto loop length sums loop-to-end repeats
// RQ2: Repeat count gives that many identical cycles
// RQ3: Override count replaces auto loop length
// RQ4: Pattern rate is conversion rate times count
// RQ5: Count change recomputes the unlocked rate
// RQ6: Nothing past the end entry loads
// RQ7: Entries before begin are discarded
// RQ8: Flag bits zero-three drive matching lines
// RQ9: Lines two, three always generator driven
// RQ10: Lines zero, one driven only when enabled
// RQ11: Only flag lines strobe acquisition
// RQ12: Programs leave reserved flag bit unused
// RQ13: DAC flag sends word to DAC
// RQ14: DAC updates only while DAC enabled
// RQ15: DAC code is straight binary
// RQ16: Idle or unused DAC holds mid-scale
// RQ17: DAC bits follow output bit order
// RQ18: DAC update still applies flag bits
// RQ19: No back-to-back DAC updates in programs
// RQ20: Begin part once, then loop continuously
// RQ21: Outputs low when not running
// RQ22: Zero count skips; count limits hold
// RQ23: One pattern word per pattern clock
// RQ24: Parallel outputs unchanged on DAC cycle
package pgd_pkg;
    localparam int ADDR_W = 16;
    localparam int REP_W = 10;
    localparam int WORD_W = 16;
    localparam int FLAG_W = 6;
    localparam int FLAG_LINES = 4;
    localparam int ENTRY_W = REP_W + FLAG_W + WORD_W;
    localparam int REG_AW = 8;
    // Entry layout: word low, flags middle, repeat count on top
    localparam int ENT_WORD_LO = 0;
    localparam int ENT_FLAG_LO = 16;
    localparam int ENT_REP_LO = 22;
    localparam int FLAG_DAC = 5;
    localparam logic [REP_W-1:0] REP_ONE = 10'h001;
    // Control register bits
    localparam int CTL_W = 7;
    localparam int CTL_RUN = 0;
    localparam int CTL_FDRV = 1;
    localparam int CTL_DAC_EN = 2;
    localparam int CTL_OVR = 3;
    localparam int CTL_LOCK = 4;
    localparam int CTL_ACQ_LO = 5;
    // Register byte offsets
    localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] REG_BEGIN = 8'h04;
    localparam logic [REG_AW-1:0] REG_LOOP = 8'h08;
    localparam logic [REG_AW-1:0] REG_END = 8'h0c;
    localparam logic [REG_AW-1:0] REG_PPC_OVR = 8'h10;
    localparam logic [REG_AW-1:0] REG_PPC = 8'h14;
    localparam logic [REG_AW-1:0] REG_PAT_PER = 8'h18;
    localparam logic [REG_AW-1:0] REG_CONV_PER = 8'h1c;
    localparam logic [REG_AW-1:0] REG_MEM_ADDR = 8'h20;
    localparam logic [REG_AW-1:0] REG_MEM_DATA = 8'h24;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h28;
    localparam logic [REG_AW-1:0] REG_DAC = 8'h2c;
    // Reset values and limits
    localparam logic [WORD_W-1:0] DAC_MID = 16'h8000;
    localparam logic [31:0] PAT_PER_MIN = 32'h0000_0004;
    localparam logic [31:0] CONV_PER_RST = 32'h0000_0004;
    localparam logic [31:0] PPC_RST = 32'h0000_0001;
    localparam logic [5:0] DIV_LAST = 6'h1f;
    typedef enum logic [1:0] {PGD_IDLE, PGD_PRIME, PGD_RUN} pgd_state_t;
endpackage

/* common/pgd_ram_if.sv */
// Port bundle between the sequencer and the entry store
`timescale 1ns/1ps
interface pgd_ram_if
    import pgd_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = ENTRY_W
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data,
                 output rd_en, output rd_addr, input rd_data);
    modport ram (input wr_en, input wr_addr, input wr_data,
                 input rd_en, input rd_addr, output rd_data);
endinterface

/* src/pgd_entry_ram.sv */
// Pattern entry store with one write and one registered read port
`timescale 1ns/1ps
module pgd_entry_ram
    import pgd_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = ENTRY_W
) (
    // Clock and freeze
    input wire logic mclk,
    input wire logic ce,
    // Store port
    pgd_ram_if.ram bus
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_q;

    // No reset: contents are loaded by software before a run
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (bus.wr_en) begin
                mem[bus.wr_addr] <= bus.wr_data;
            end
            if (bus.rd_en) begin
                rd_q <= mem[bus.rd_addr];
            end
        end
    end

    assign bus.rd_data = rd_q;
endmodule

/* src/pgd_top.sv */
// Looping pattern generator with APB registers and waveform DAC path
`timescale 1ns/1ps
module pgd_top
    import pgd_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // Clock, freeze and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [REG_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Parallel pattern outputs
    output logic [WORD_W-1:0] pattern_out,
    // Flag lines zero and one, two-way toward the daughtercard
    input wire logic [1:0] flag_lo_i,
    output logic [1:0] flag_lo_o,
    output logic [1:0] flag_lo_oe_n,
    // Flag lines two and three
    output logic [1:0] flag_hi_o,
    // Acquisition strobe toward the data collector
    output logic acq_strobe,
    // Waveform DAC
    output logic [WORD_W-1:0] awo_code,
    output logic awo_load,
    output logic awo_enable
);
    pgd_ram_if #(.AW(AW), .DW(ENTRY_W)) ram_bus ();

    function automatic logic [REP_W-1:0] ent_rep(input logic [ENTRY_W-1:0] e);
        return e[ENT_REP_LO +: REP_W];
    endfunction

    function automatic logic [31:0] clamp_per(input logic [31:0] v);
        return (v < PAT_PER_MIN) ? PAT_PER_MIN : v;
    endfunction

    // Register and rate group
    logic [CTL_W-1:0] ctrl_q, ctrl_d;
    logic [AW-1:0] begin_q, begin_d, loop_q, loop_d, end_q, end_d;
    logic [AW-1:0] mem_addr_q, mem_addr_d;
    logic [31:0] ppc_ovr_q, ppc_ovr_d, pat_per_q, pat_per_d, conv_per_q, conv_per_d;
    logic [31:0] prdata_q, prdata_d, ppc_seen_q, ppc_seen_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, recalc_q, recalc_d;
    logic div_busy_q, div_busy_d;
    logic [5:0] div_cnt_q, div_cnt_d;
    logic [31:0] div_rem_q, div_rem_d, div_quo_q, div_quo_d, div_den_q, div_den_d;
    logic [32:0] rem_sh;
    logic [31:0] quo_sh;
    logic [63:0] prod;
    // Sequencer group
    pgd_state_t state_q, state_d;
    logic [31:0] per_cnt_q, per_cnt_d, loop_cnt_q, loop_cnt_d, auto_ppc_q, auto_ppc_d;
    logic [AW-1:0] cur_idx_q, cur_idx_d, nxt_idx_q, nxt_idx_d, ahead_q, ahead_d;
    logic [REP_W-1:0] rep_q, rep_d;
    logic [ENTRY_W-1:0] nxt_ent_q, nxt_ent_d;
    logic nxt_valid_q, nxt_valid_d, nxt_wrap_q, nxt_wrap_d, ahead_wrap_q, ahead_wrap_d;
    logic rd_pend_q, rd_pend_d, in_loop_q, in_loop_d, last_dac_q, last_dac_d;
    logic underrun_q, underrun_d, dac_load_q, dac_load_d;
    logic [WORD_W-1:0] out_q, out_d, dac_code_q, dac_code_d;
    logic [FLAG_LINES-1:0] flags_q, flags_d;
    // Pin group
    logic [1:0] flag_meta_q, flag_sync_q, oe_n_q, oe_n_d;
    logic [FLAG_LINES-1:0] seen;
    logic acq_prev_q, acq_prev_d, acq_q, acq_d;
    // Shared terms
    logic setup, wr_acc, tick, ld;
    logic [31:0] ppc_eff;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign tick = (state_q == PGD_RUN) && (per_cnt_q == '0);
    assign ppc_eff = ctrl_q[CTL_OVR] ? ppc_ovr_q : auto_ppc_q; // RQ3

    always_comb begin
        ctrl_d = ctrl_q;
        begin_d = begin_q;
        loop_d = loop_q;
        end_d = end_q;
        mem_addr_d = mem_addr_q;
        ppc_ovr_d = ppc_ovr_q;
        pat_per_d = pat_per_q;
        conv_per_d = conv_per_q;
        ppc_seen_d = ppc_seen_q;
        recalc_d = recalc_q;
        div_busy_d = div_busy_q;
        div_cnt_d = div_cnt_q;
        div_rem_d = div_rem_q;
        div_quo_d = div_quo_q;
        div_den_d = div_den_q;
        rem_sh = {div_rem_q, div_quo_q[31]};
        quo_sh = {div_quo_q[30:0], 1'b0};
        prod = 64'(pat_per_q) * 64'(ppc_eff);
        ram_bus.wr_en = 1'b0;
        ram_bus.wr_addr = mem_addr_q;
        ram_bus.wr_data = pwdata;
        pready_d = setup;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (setup) begin
            case (paddr)
                REG_CTRL: prdata_d = 32'(ctrl_q);
                REG_BEGIN: prdata_d = 32'(begin_q);
                REG_LOOP: prdata_d = 32'(loop_q);
                REG_END: prdata_d = 32'(end_q);
                REG_PPC_OVR: prdata_d = ppc_ovr_q;
                REG_PPC: prdata_d = ppc_eff;
                REG_PAT_PER: prdata_d = pat_per_q;
                REG_CONV_PER: prdata_d = conv_per_q;
                REG_MEM_ADDR: prdata_d = 32'(mem_addr_q);
                REG_MEM_DATA: prdata_d = '0;
                REG_STATUS: prdata_d = {16'(cur_idx_q), 14'h0, underrun_q,
                                        state_q == PGD_RUN};
                REG_DAC: prdata_d = 32'(dac_code_q);
                default: begin
                    prdata_d = '0;
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                REG_CTRL: ctrl_d = pwdata[CTL_W-1:0];
                REG_BEGIN: begin_d = pwdata[AW-1:0];
                REG_LOOP: loop_d = pwdata[AW-1:0];
                REG_END: end_d = pwdata[AW-1:0];
                REG_PPC_OVR: ppc_ovr_d = pwdata;
                REG_PAT_PER: begin
                    pat_per_d = clamp_per(pwdata);
                    recalc_d = 1'b1;
                end
                REG_CONV_PER: begin
                    conv_per_d = pwdata;
                    recalc_d = 1'b1;
                end
                REG_MEM_ADDR: mem_addr_d = pwdata[AW-1:0];
                REG_MEM_DATA: begin
                    ram_bus.wr_en = 1'b1;
                    mem_addr_d = mem_addr_q + 1'b1;
                end
                default: ;
            endcase
        end
        // Shift-subtract divider; one quotient bit per cycle keeps it small
        if (div_busy_q) begin
            if (rem_sh >= {1'b0, div_den_q}) begin
                rem_sh = rem_sh - {1'b0, div_den_q};
                quo_sh[0] = 1'b1;
            end
            div_rem_d = rem_sh[31:0];
            div_quo_d = quo_sh;
            div_cnt_d = div_cnt_q + 1'b1;
            if (div_cnt_q == DIV_LAST) begin
                div_busy_d = 1'b0;
                pat_per_d = clamp_per(quo_sh); // RQ4 RQ5
            end
        end else if (!wr_acc && (recalc_q || ppc_eff != ppc_seen_q)) begin
            ppc_seen_d = ppc_eff;
            recalc_d = 1'b0;
            if (!ctrl_q[CTL_LOCK]) begin
                conv_per_d = prod[31:0]; // RQ4 RQ5
            end else if (ppc_eff != '0) begin
                div_busy_d = 1'b1; // RQ5
                div_cnt_d = '0;
                div_rem_d = '0;
                div_quo_d = conv_per_q;
                div_den_d = ppc_eff;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= '0;
            begin_q <= '0;
            loop_q <= '0;
            end_q <= '0;
            mem_addr_q <= '0;
            ppc_ovr_q <= PPC_RST;
            pat_per_q <= PAT_PER_MIN;
            conv_per_q <= CONV_PER_RST;
            ppc_seen_q <= PPC_RST;
            recalc_q <= 1'b0;
            div_busy_q <= 1'b0;
            div_cnt_q <= '0;
            div_rem_q <= '0;
            div_quo_q <= '0;
            div_den_q <= PPC_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            begin_q <= begin_d;
            loop_q <= loop_d;
            end_q <= end_d;
            mem_addr_q <= mem_addr_d;
            ppc_ovr_q <= ppc_ovr_d;
            pat_per_q <= pat_per_d;
            conv_per_q <= conv_per_d;
            ppc_seen_q <= ppc_seen_d;
            recalc_q <= recalc_d;
            div_busy_q <= div_busy_d;
            div_cnt_q <= div_cnt_d;
            div_rem_q <= div_rem_d;
            div_quo_q <= div_quo_d;
            div_den_q <= div_den_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    always_comb begin
        state_d = state_q;
        per_cnt_d = per_cnt_q;
        loop_cnt_d = loop_cnt_q;
        auto_ppc_d = auto_ppc_q;
        cur_idx_d = cur_idx_q;
        nxt_idx_d = nxt_idx_q;
        ahead_d = ahead_q;
        rep_d = rep_q;
        nxt_ent_d = nxt_ent_q;
        nxt_valid_d = nxt_valid_q;
        nxt_wrap_d = nxt_wrap_q;
        ahead_wrap_d = ahead_wrap_q;
        rd_pend_d = rd_pend_q;
        in_loop_d = in_loop_q;
        last_dac_d = last_dac_q;
        underrun_d = underrun_q;
        out_d = out_q;
        flags_d = flags_q;
        dac_code_d = dac_code_q;
        dac_load_d = 1'b0;
        ld = 1'b0;
        ram_bus.rd_en = 1'b0;
        ram_bus.rd_addr = ahead_q;
        // Fetch ahead; zero-count runs must fit in one pattern period
        if (state_q != PGD_IDLE && !nxt_valid_q) begin
            if (!rd_pend_q) begin
                ram_bus.rd_en = 1'b1;
                rd_pend_d = 1'b1;
            end else begin
                rd_pend_d = 1'b0;
                ahead_d = (ahead_q == end_q) ? loop_q : ahead_q + 1'b1; // RQ6 RQ20
                if (ent_rep(ram_bus.rd_data) != '0) begin // RQ22
                    nxt_valid_d = 1'b1;
                    nxt_ent_d = ram_bus.rd_data;
                    nxt_idx_d = ahead_q;
                    nxt_wrap_d = ahead_wrap_q;
                    ahead_wrap_d = (ahead_q == end_q);
                end else begin
                    ahead_wrap_d = ahead_wrap_q || (ahead_q == end_q);
                end
            end
        end
        case (state_q)
            PGD_IDLE: begin
                state_d = PGD_PRIME;
                ahead_d = begin_q; // RQ7
                ahead_wrap_d = 1'b0;
                nxt_valid_d = 1'b0;
                rd_pend_d = 1'b0;
                in_loop_d = 1'b0;
                loop_cnt_d = '0;
                rep_d = '0;
                per_cnt_d = '0;
                last_dac_d = 1'b0;
                underrun_d = 1'b0;
            end
            PGD_PRIME: begin
                if (nxt_valid_q) begin
                    state_d = PGD_RUN;
                end
            end
            PGD_RUN: begin
                if (!tick) begin
                    per_cnt_d = per_cnt_q - 32'h1;
                end else begin
                    per_cnt_d = pat_per_q - 32'h1; // RQ23
                    last_dac_d = 1'b0;
                    if (rep_q > REP_ONE) begin
                        rep_d = rep_q - 1'b1; // RQ2
                    end else if (nxt_valid_q) begin
                        ld = 1'b1;
                    end else begin
                        underrun_d = 1'b1;
                    end
                    if (ld && nxt_wrap_q) begin
                        auto_ppc_d = loop_cnt_q; // RQ1
                        loop_cnt_d = 32'h1;
                    end else if (in_loop_q || (ld && nxt_idx_q >= loop_q)) begin
                        in_loop_d = 1'b1;
                        loop_cnt_d = loop_cnt_q + 32'h1; // RQ1
                    end
                    if (ld) begin
                        nxt_valid_d = 1'b0;
                        cur_idx_d = nxt_idx_q;
                        rep_d = ent_rep(nxt_ent_q);
                        // Reserved flag bit four is never looked at
                        flags_d = nxt_ent_q[ENT_FLAG_LO +: FLAG_LINES]; // RQ8 RQ18
                        if (nxt_ent_q[ENT_FLAG_LO + FLAG_DAC]) begin
                            last_dac_d = 1'b1;
                            // A second update in a row is dropped, not queued
                            if (ctrl_q[CTL_DAC_EN] && ctrl_d[CTL_DAC_EN]
                                    && !last_dac_q) begin // RQ14 RQ19
                                dac_code_d = nxt_ent_q[ENT_WORD_LO +: WORD_W]; // RQ13 RQ15 RQ17
                                dac_load_d = 1'b1;
                            end
                        end else begin
                            out_d = nxt_ent_q[ENT_WORD_LO +: WORD_W]; // RQ24
                        end
                    end
                end
            end
            default: state_d = PGD_IDLE;
        endcase
        if (!ctrl_q[CTL_RUN]) begin
            state_d = PGD_IDLE;
            out_d = '0; // RQ21
            flags_d = '0;
        end
        if (!ctrl_q[CTL_RUN] || !ctrl_q[CTL_DAC_EN]) begin
            dac_code_d = DAC_MID; // RQ16
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PGD_IDLE;
            per_cnt_q <= '0;
            loop_cnt_q <= '0;
            auto_ppc_q <= PPC_RST;
            cur_idx_q <= '0;
            nxt_idx_q <= '0;
            ahead_q <= '0;
            rep_q <= '0;
            nxt_ent_q <= '0;
            nxt_valid_q <= 1'b0;
            nxt_wrap_q <= 1'b0;
            ahead_wrap_q <= 1'b0;
            rd_pend_q <= 1'b0;
            in_loop_q <= 1'b0;
            last_dac_q <= 1'b0;
            underrun_q <= 1'b0;
            out_q <= '0;
            flags_q <= '0;
            dac_code_q <= DAC_MID;
            dac_load_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            per_cnt_q <= per_cnt_d;
            loop_cnt_q <= loop_cnt_d;
            auto_ppc_q <= auto_ppc_d;
            cur_idx_q <= cur_idx_d;
            nxt_idx_q <= nxt_idx_d;
            ahead_q <= ahead_d;
            rep_q <= rep_d;
            nxt_ent_q <= nxt_ent_d;
            nxt_valid_q <= nxt_valid_d;
            nxt_wrap_q <= nxt_wrap_d;
            ahead_wrap_q <= ahead_wrap_d;
            rd_pend_q <= rd_pend_d;
            in_loop_q <= in_loop_d;
            last_dac_q <= last_dac_d;
            underrun_q <= underrun_d;
            out_q <= out_d;
            flags_q <= flags_d;
            dac_code_q <= dac_code_d;
            dac_load_q <= dac_load_d;
        end
    end

    always_comb begin
        seen = {flags_q[3:2], ctrl_q[CTL_FDRV] ? flags_q[1:0] : flag_sync_q}; // RQ9 RQ10
        acq_prev_d = seen[ctrl_q[CTL_ACQ_LO +: 2]];
        acq_d = acq_prev_d && !acq_prev_q; // RQ11
        oe_n_d = {2{~ctrl_q[CTL_FDRV]}}; // RQ10
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag_meta_q <= '0;
            flag_sync_q <= '0;
            oe_n_q <= 2'h3;
            acq_prev_q <= 1'b0;
            acq_q <= 1'b0;
        end else if (ce) begin
            flag_meta_q <= flag_lo_i;
            flag_sync_q <= flag_meta_q;
            oe_n_q <= oe_n_d;
            acq_prev_q <= acq_prev_d;
            acq_q <= acq_d;
        end
    end

    pgd_entry_ram #(.AW(AW), .DW(ENTRY_W)) u_ram (
        .mclk(mclk),
        .ce(ce),
        .bus(ram_bus.ram)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pattern_out = out_q;
    assign flag_lo_o = flags_q[1:0];
    assign flag_lo_oe_n = oe_n_q;
    assign flag_hi_o = flags_q[3:2];
    assign acq_strobe = acq_q;
    assign awo_code = dac_code_q;
    assign awo_load = dac_load_q;
    assign awo_enable = ctrl_q[CTL_DAC_EN];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_idle_outs_low: assert property ( // RQ21
        ce && !ctrl_q[CTL_RUN] |=> out_q == '0 && flags_q == '0)
        else $error("Outputs not low while stopped");
    a_dac_mid_idle: assert property ( // RQ16
        ce && !(ctrl_q[CTL_RUN] && ctrl_q[CTL_DAC_EN]) |=> dac_code_q == DAC_MID)
        else $error("DAC code not mid-scale while unused");
    a_dac_needs_en: assert property ( // RQ14
        dac_load_q |-> $past(ctrl_q[CTL_DAC_EN]) && ctrl_q[CTL_DAC_EN])
        else $error("DAC updated while disabled");
    a_dac_keeps_out: assert property ( // RQ24
        dac_load_q |-> out_q == $past(out_q, 1))
        else $error("Parallel outputs moved on a DAC update");
    a_fdrv_off: assert property ( // RQ10
        ce && !ctrl_q[CTL_FDRV] |=> flag_lo_oe_n == 2'h3)
        else $error("Low flag lines driven without enable");
    a_step_on_tick: assert property ( // RQ23
        $changed(cur_idx_q) |-> $past(tick))
        else $error("Entry advanced off a pattern tick");
    a_rep_count: assert property ( // RQ2
        ce && tick && rep_q > REP_ONE |=> rep_q == $past(rep_q) - 1)
        else $error("Repeat count did not step down by one");
    a_skip_zero: assert property ( // RQ22
        nxt_valid_q |-> ent_rep(nxt_ent_q) != '0)
        else $error("Zero-count entry queued");
endmodule

/* testbench/pgd_card_model.sv */
// Daughtercard side of flag lines zero and one
`timescale 1ns/1ps
module pgd_card_model (
    // Clock
    input wire logic mclk,
    // Device side of the two-way lines
    input wire logic [1:0] drv,
    input wire logic [1:0] drv_n,
    // Resolved line levels
    output logic [1:0] line
);
    logic [1:0] card_q = 2'h0;
    // Card keeps toggling so a stale device level never passes for a match
    always @(posedge mclk) begin
        card_q <= card_q + 2'h1;
    end
    // Device owns a line only while its enable is low
    assign line = {drv_n[1] ? card_q[1] : drv[1], drv_n[0] ? card_q[0] : drv[0]};
endmodule

/* testbench/tb.sv */
// Self-checking bench of the looping pattern generator
`timescale 1ns/1ps
module tb;
    import pgd_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, acq_strobe, awo_load, awo_enable, er;
    logic [15:0] pattern_out, awo_code;
    logic [1:0] flag_lo_i, flag_lo_o, flag_lo_oe_n, flag_hi_o;
    int err_total = 0, samples_checked = 0, cycles = 0;
    always #10 mclk = ~mclk;
    pgd_top i_pgd_top (.mclk(mclk), .resetn(resetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pattern_out(pattern_out),
        .flag_lo_i(flag_lo_i), .flag_lo_o(flag_lo_o), .flag_lo_oe_n(flag_lo_oe_n),
        .flag_hi_o(flag_hi_o), .acq_strobe(acq_strobe), .awo_code(awo_code),
        .awo_load(awo_load), .awo_enable(awo_enable));
    pgd_card_model i_pgd_card_model (.mclk(mclk), .drv(flag_lo_o), .drv_n(flag_lo_oe_n),
        .line(flag_lo_i));
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            give_verdict;
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Run the program for 160 cycles and judge the word sequence on the outputs
    task run_seq(input logic [31:0] ctl, input logic dac);
        logic [15:0] seen[$];
        logic [15:0] last;
        int loads, dacflag, acq, n;
        int tq[$];
        last = 16'h0; loads = 0; dacflag = 0; acq = 0;
        n = 0;
        seen.delete();
        tq.delete();
        apb(1'b1, REG_CTRL, ctl);
        repeat (160) begin
            @(negedge mclk);
            n++;
            if (pattern_out !== last) begin
                seen.push_back(pattern_out);
                tq.push_back(n);
            end
            last = pattern_out;
            loads += (awo_load === 1'b1);
            acq += (acq_strobe === 1'b1);
            dacflag += (pattern_out === 16'h0002 && flag_hi_o === 2'b01);
            if (pattern_out === 16'h0005) chk("flag_hi", 2'b11, flag_hi_o);
            if (pattern_out === 16'h0002 && flag_hi_o === 2'b00) chk("flag_lo", 2'b11, flag_lo_o);
        end
        chk("len", 1, seen.size() >= 5);
        chk("w0", 16'h0001, seen[0]);
        chk("w1", 16'h0002, seen[1]);
        chk("w2", 16'h0005, seen[2]);
        chk("w3", 16'h0002, seen[3]);
        chk("w4", 16'h0005, seen[4]);
        chk("t_end", PAT_PER_MIN, tq[3] - tq[2]);
        chk("t_loop", PAT_PER_MIN * 4, tq[4] - tq[3]);
        chk("dac_flags", 1, dacflag > 0);
        chk("oe_n", dac ? 2'b11 : 2'b00, flag_lo_oe_n);
        chk("awo_code", dac ? 16'hffff : DAC_MID, awo_code);
        chk("awo_load", dac, loads > 0);
        chk("awo_en", dac, awo_enable);
        if (!dac) chk("acq", 1, acq > 0);
        apb(1'b0, REG_PPC, 32'h0);
        chk("ppc_auto", 32'h5, rd);
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (3) @(negedge mclk);
        chk("stop_word", 16'h0, pattern_out);
        chk("stop_dac", DAC_MID, awo_code);
        $display("run with dac %0d done", dac);
    endtask
    task program_load;
        logic [31:0] ent[7];
        ent = '{{10'h1, 6'h00, 16'hdead}, {10'h1, 6'h00, 16'h0001}, {10'h3, 6'h03, 16'h0002},
                {10'h0, 6'h00, 16'h0bad}, {10'h1, 6'h24, 16'hffff}, {10'h1, 6'h0c, 16'h0005},
                {10'h1, 6'h00, 16'h0eee}};
        apb(1'b1, REG_MEM_ADDR, 32'h0);
        foreach (ent[i]) apb(1'b1, REG_MEM_DATA, ent[i]);
        apb(1'b1, REG_BEGIN, 32'h1);
        apb(1'b1, REG_LOOP, 32'h2);
        apb(1'b1, REG_END, 32'h5);
        $display("program loaded");
    endtask
    task reg_checks;
        apb(1'b1, REG_PPC_OVR, 32'h4);
        apb(1'b1, REG_CTRL, 32'h8);
        apb(1'b0, REG_PPC, 32'h0);
        chk("ppc_override", 32'h4, rd);
        apb(1'b0, REG_CONV_PER, 32'h0);
        chk("conv_unlocked", PAT_PER_MIN * 4, rd);
        apb(1'b1, REG_CTRL, 32'h18);
        apb(1'b1, REG_CONV_PER, 32'h40);
        // Locked rate goes through the serial divider
        repeat (40) @(posedge mclk);
        apb(1'b0, REG_PAT_PER, 32'h0);
        chk("pat_locked", 32'h40 / 4, rd);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped_err", 1'b1, er);
        chk("unmapped_data", 32'h0, rd);
        $display("register test done");
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        chk("rst_word", 16'h0, pattern_out);
        chk("rst_dac", DAC_MID, awo_code);
        chk("rst_oe_n", 2'b11, flag_lo_oe_n);
        program_load;
        run_seq(32'h3, 1'b0);
        run_seq(32'h5, 1'b1);
        reg_checks;
        give_verdict;
    end
endmodule
